// file: src/rcl_link_timer.sv
// Reverse-channel link-detect timer
`timescale 1ns/100ps
`default_nettype none
module rcl_link_timer #(
	parameter logic [15:0] CYC_325_P  = rcl_pkg::CYC_325,
	parameter logic [15:0] CYC_650_P  = rcl_pkg::CYC_650,
	parameter logic [15:0] CYC_1300_P = rcl_pkg::CYC_1300
) (
	input  wire logic                     clock,
	input  wire logic                     nrst,
	input  wire logic [rcl_pkg::SEL_W-1:0] sel,
	input  wire logic                     rev_valid,
	output var  logic                     link_up
);
	import rcl_pkg::*;

	logic [15:0] period;
	logic [15:0] count_reg;

	// Timeout select decode
	always_comb begin
		case (sel)
			3'h0: period = CYC_162;
			3'h1: period = CYC_325_P;
			3'h2: period = CYC_650_P;
			3'h3: period = CYC_1300_P;
			3'h4: period = CYC_10_25;
			3'h5: period = CYC_20_5;
			3'h6: period = CYC_41;
			default: period = CYC_82;
		endcase
	end

	// Countdown, reloaded by each valid reception
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_reg <= 16'h0000;
		end else if (rev_valid) begin
			count_reg <= period;
		end else if (count_reg != 16'h0000) begin
			count_reg <= count_reg - 16'h0001;
		end
	end

	// Link detect falls on the last count; a new select applies at next reload
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			link_up <= 1'b0;
		end else if (rev_valid) begin
			link_up <= 1'b1;
		end else if (count_reg == 16'h0001) begin
			link_up <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	a_timeout_drop: assert property (
		(count_reg == 16'h0001 && !rev_valid) |=> !link_up && count_reg == 16'h0000)
		else $error("link detect not dropped at timeout");
	a_period_reload: assert property (
		rev_valid |=> count_reg == $past(period) &&
			(($past(sel) == 3'h4) -> count_reg == CYC_10_25))
		else $error("timer reload value wrong");
	a_traffic_keeps: assert property (
		rev_valid ##1 !rev_valid [*3] |-> link_up)
		else $error("link detect lost despite fresh traffic");

endmodule
`default_nettype wire

// file: src/rcl_pkg.sv
// Constants and types for the remote capability and link-detect bank
// Notes on behaviour
// - Capabilities auto-load from back channel after lock
// - Software writes persist only with hold set
// - Hold bit 7 freezes capability fields
// - Bit 4 sends equalizer training pattern
// - Bit 3 flags two-link capable receiver
// - Bit 2 selects primary or secondary channel
// - Bit 1 flags wide video with HD sound
// - Bit 0 flags pin states in frame
// - Timer drops link detect without traffic
// - Three-bit field selects one of eight timeouts
package rcl_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] CAP_FLAGS_ADDR  = 8'h20;
	localparam logic [7:0] CAP_EXTRA_ADDR  = 8'h21;
	localparam logic [7:0] LINK_CTRL_ADDR  = 8'h26;
	localparam logic [7:0] CAP_FLAGS_RESET = 8'h00;
	localparam logic [2:0] LINK_CTRL_RESET = 3'h0;
	localparam int         HOLD_BIT        = 7;
	localparam int         EQ_BIT          = 4;
	localparam int         TWO_LINK_BIT    = 3;
	localparam int         CHAN_BIT        = 2;
	localparam int         WIDE_VID_BIT    = 1;
	localparam int         PIN_FRAME_BIT   = 0;
	localparam int         SEL_W           = 3;
	// Writable bits and the bits the back channel may refresh
	localparam logic [7:0] CAP_WMASK       = 8'h9F;
	localparam logic [7:0] CAP_AUTO_MASK   = 8'h1F;
	// Arbitrary neutral bus address of this device
	localparam logic [6:0] I2C_DEV_ADDR    = 7'h0C;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int TO_162_NS     = 162000;
	localparam int TO_325_NS     = 325000;
	localparam int TO_650_NS     = 650000;
	localparam int TO_1300_NS    = 1300000;
	localparam int TO_10_25_NS   = 10250;
	localparam int TO_20_5_NS    = 20500;
	localparam int TO_41_NS      = 41000;
	localparam int TO_82_NS      = 82000;
	localparam logic [15:0] CYC_162   = 16'(TO_162_NS / CLK_PERIOD_NS);
	localparam logic [15:0] CYC_325   = 16'(TO_325_NS / CLK_PERIOD_NS);
	localparam logic [15:0] CYC_650   = 16'(TO_650_NS / CLK_PERIOD_NS);
	localparam logic [15:0] CYC_1300  = 16'(TO_1300_NS / CLK_PERIOD_NS);
	localparam logic [15:0] CYC_10_25 = 16'(TO_10_25_NS / CLK_PERIOD_NS);
	localparam logic [15:0] CYC_20_5  = 16'(TO_20_5_NS / CLK_PERIOD_NS);
	localparam logic [15:0] CYC_41    = 16'(TO_41_NS / CLK_PERIOD_NS);
	localparam logic [15:0] CYC_82    = 16'(TO_82_NS / CLK_PERIOD_NS);

	// ****************************************
	// Serial control bus states
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_DEV     = 4'h1,
		ST_DEV_ACK = 4'h3,
		ST_PTR     = 4'h2,
		ST_PTR_ACK = 4'h6,
		ST_WR      = 4'h7,
		ST_WR_ACK  = 4'h5,
		ST_RD      = 4'h4,
		ST_RD_ACK  = 4'hC
	} rcl_bus_e;

endpackage

// file: src/rcl_top.sv
// Remote capability register bank with link-detect timer and serial slave
`timescale 1ns/100ps
`default_nettype none
module rcl_top #(
	parameter logic [15:0] CYC_325_P  = rcl_pkg::CYC_325,
	parameter logic [15:0] CYC_650_P  = rcl_pkg::CYC_650,
	parameter logic [15:0] CYC_1300_P = rcl_pkg::CYC_1300
) (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output var  logic       sda_out,
	output var  logic       sda_oe,
	input  wire logic       rx_lock,
	input  wire logic       cap_load_valid,
	input  wire logic [7:0] cap_load_data,
	input  wire logic       rev_valid,
	output var  logic       send_equalizer_pattern,
	output var  logic       two_link_capable,
	output var  logic       secondary_channel,
	output var  logic       wide_video_with_hd_sound,
	output var  logic       forward_frame_pin_support,
	output var  logic       link_detect
);
	import rcl_pkg::*;

	logic           scl_s1, scl_s2, scl_d;
	logic           sda_s1, sda_s2, sda_d;
	logic           lock_s1, lock_s2;
	logic           scl_rise, scl_fall, bus_start, bus_stop;
	rcl_bus_e       state_reg;
	logic [2:0]     bit_cnt_reg;
	logic [7:0]     shift_reg;
	logic           full_reg;
	logic           rw_reg;
	logic [7:0]     ptr_reg;
	logic [7:0]     rd_data;
	logic           wr_stb;
	logic           wr_cap;
	logic           hold;
	logic           auto_load;
	logic [7:0]     cap_reg;
	logic [SEL_W-1:0] sel_reg;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Idle bus lines reset high so no false start after reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			scl_s1  <= 1'b1;
			scl_s2  <= 1'b1;
			scl_d   <= 1'b1;
			sda_s1  <= 1'b1;
			sda_s2  <= 1'b1;
			sda_d   <= 1'b1;
			lock_s1 <= 1'b0;
			lock_s2 <= 1'b0;
		end else begin
			scl_s1  <= scl_in;
			scl_s2  <= scl_s1;
			scl_d   <= scl_s2;
			sda_s1  <= sda_in;
			sda_s2  <= sda_s1;
			sda_d   <= sda_s2;
			lock_s1 <= rx_lock;
			lock_s2 <= lock_s1;
		end
	end

	// Edge and bus condition detect on synchronised levels only
	assign scl_rise  = scl_s2 & ~scl_d;
	assign scl_fall  = ~scl_s2 & scl_d;
	assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

	// ****************************************
	// Serial control bus slave
	// ****************************************
	// Read mux; unmapped and reserved addresses read as zero
	always_comb begin
		case (ptr_reg)
			CAP_FLAGS_ADDR: rd_data = cap_reg;
			LINK_CTRL_ADDR: rd_data = {5'h00, sel_reg};
			default:        rd_data = 8'h00;
		endcase
	end

	// Data byte completes on the falling clock after its eighth bit
	assign wr_stb = scl_fall & ~bus_start & ~bus_stop & (state_reg == ST_WR) & full_reg;

	// Byte engine: sample on rising clock, drive on falling clock
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_reg   <= ST_IDLE;
			bit_cnt_reg <= 3'h0;
			shift_reg   <= 8'h00;
			full_reg    <= 1'b0;
			rw_reg      <= 1'b0;
			ptr_reg     <= 8'h00;
			sda_oe      <= 1'b0;
		end else if (bus_stop) begin
			state_reg <= ST_IDLE;
			sda_oe    <= 1'b0;
		end else if (bus_start) begin
			state_reg   <= ST_DEV;
			bit_cnt_reg <= 3'h0;
			full_reg    <= 1'b0;
			sda_oe      <= 1'b0;
		end else if (scl_rise) begin
			unique case (state_reg)
				ST_DEV, ST_PTR, ST_WR: begin
					shift_reg   <= {shift_reg[6:0], sda_s2};
					bit_cnt_reg <= bit_cnt_reg + 3'h1;
					full_reg    <= (bit_cnt_reg == 3'h7);
				end
				// Master refusal ends a read burst
				ST_RD_ACK: begin
					if (sda_s2) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			unique case (state_reg)
				ST_IDLE: begin
				end
				ST_DEV: begin
					if (full_reg) begin
						full_reg <= 1'b0;
						if (shift_reg[7:1] == I2C_DEV_ADDR) begin
							state_reg <= ST_DEV_ACK;
							rw_reg    <= shift_reg[0];
							sda_oe    <= 1'b1;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_DEV_ACK: begin
					if (rw_reg) begin
						state_reg <= ST_RD;
						shift_reg <= rd_data;
						sda_oe    <= ~rd_data[7];
					end else begin
						state_reg <= ST_PTR;
						sda_oe    <= 1'b0;
					end
				end
				ST_PTR: begin
					if (full_reg) begin
						full_reg  <= 1'b0;
						ptr_reg   <= shift_reg;
						state_reg <= ST_PTR_ACK;
						sda_oe    <= 1'b1;
					end
				end
				ST_PTR_ACK: begin
					state_reg <= ST_WR;
					sda_oe    <= 1'b0;
				end
				ST_WR: begin
					if (full_reg) begin
						full_reg  <= 1'b0;
						state_reg <= ST_WR_ACK;
						sda_oe    <= 1'b1;
					end
				end
				// Pointer steps so bursts walk the map
				ST_WR_ACK: begin
					ptr_reg   <= ptr_reg + 8'h01;
					state_reg <= ST_WR;
					sda_oe    <= 1'b0;
				end
				ST_RD: begin
					if (bit_cnt_reg == 3'h7) begin
						bit_cnt_reg <= 3'h0;
						ptr_reg     <= ptr_reg + 8'h01;
						state_reg   <= ST_RD_ACK;
						sda_oe      <= 1'b0;
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						shift_reg   <= {shift_reg[6:0], 1'b0};
						sda_oe      <= ~shift_reg[6];
					end
				end
				ST_RD_ACK: begin
					state_reg <= ST_RD;
					shift_reg <= rd_data;
					sda_oe    <= ~rd_data[7];
				end
				default: begin
					state_reg <= ST_IDLE;
					sda_oe    <= 1'b0;
				end
			endcase
		end
	end

	// Open-drain: the line is only ever pulled low
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// ****************************************
	// Capability and timeout registers
	// ****************************************
	assign wr_cap    = wr_stb & (ptr_reg == CAP_FLAGS_ADDR);
	assign hold      = cap_reg[HOLD_BIT];
	assign auto_load = lock_s2 & cap_load_valid & ~hold & ~wr_cap;

	// Software write beats a same-cycle refresh; hold blocks refresh
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cap_reg <= CAP_FLAGS_RESET;
		end else if (wr_cap) begin
			cap_reg <= shift_reg & CAP_WMASK;
		end else if (auto_load) begin
			cap_reg <= (cap_load_data & CAP_AUTO_MASK) | (cap_reg & ~CAP_AUTO_MASK);
		end
	end

	// Timeout select field
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sel_reg <= LINK_CTRL_RESET;
		end else if (wr_stb && ptr_reg == LINK_CTRL_ADDR) begin
			sel_reg <= shift_reg[SEL_W-1:0];
		end
	end

	// Capability outputs, registered once more for clean pins
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			send_equalizer_pattern    <= 1'b0;
			two_link_capable          <= 1'b0;
			secondary_channel         <= 1'b0;
			wide_video_with_hd_sound  <= 1'b0;
			forward_frame_pin_support <= 1'b0;
		end else begin
			send_equalizer_pattern    <= cap_reg[EQ_BIT];
			two_link_capable          <= cap_reg[TWO_LINK_BIT];
			secondary_channel         <= cap_reg[CHAN_BIT];
			wide_video_with_hd_sound  <= cap_reg[WIDE_VID_BIT];
			forward_frame_pin_support <= cap_reg[PIN_FRAME_BIT];
		end
	end

	// Link-detect timer
	rcl_link_timer #(
		.CYC_325_P  (CYC_325_P),
		.CYC_650_P  (CYC_650_P),
		.CYC_1300_P (CYC_1300_P)
	) u_timer (
		.clock     (clock),
		.nrst      (nrst),
		.sel       (sel_reg),
		.rev_valid (rev_valid),
		.link_up   (link_detect)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence s_load_req;
		lock_s2 && cap_load_valid && !hold && !wr_cap;
	endsequence

	sequence s_eq_seen;
		##1 send_equalizer_pattern == $past(cap_load_data[EQ_BIT], 2);
	endsequence

	a_auto_load: assert property (
		s_load_req |=> cap_reg[4:0] == $past(cap_load_data[4:0]))
		else $error("capability auto-load missed");
	a_sw_persist: assert property (
		(wr_cap ##1 hold [*4]) |-> $stable(cap_reg[4:0]) or $past(wr_cap))
		else $error("held software value overwritten");
	a_hold_freeze: assert property (
		(hold && !wr_cap) |=> $stable(cap_reg))
		else $error("capabilities changed while held");
	a_eq_pin: assert property (
		(s_load_req ##1 !wr_cap) |-> s_eq_seen)
		else $error("equalizer request not forwarded");
	a_two_link: assert property (
		##1 two_link_capable == $past(cap_reg[TWO_LINK_BIT]))
		else $error("two-link flag mismatch");
	a_chan_sel: assert property (
		##1 secondary_channel == $past(cap_reg[CHAN_BIT]))
		else $error("channel select mismatch");
	a_wide_video: assert property (
		##1 wide_video_with_hd_sound == $past(cap_reg[WIDE_VID_BIT]))
		else $error("wide video flag mismatch");
	a_pin_frame: assert property (
		##1 forward_frame_pin_support == $past(cap_reg[PIN_FRAME_BIT]))
		else $error("frame pin flag mismatch");
	a_rsvd_zero: assert property (
		cap_reg[6:5] == 2'b00 && (ptr_reg == CAP_EXTRA_ADDR -> rd_data == 8'h00))
		else $error("reserved bits not zero");

endmodule
`default_nettype wire

// file: tb/rcl_peer.sv
// Behavioural remote receiver driving the back-channel side of the bank
`timescale 1ns/100ps
`default_nettype none
module rcl_peer (
	input  wire logic       clock,
	output var  logic       rx_lock,
	output var  logic       cap_load_valid,
	output var  logic [7:0] cap_load_data,
	output var  logic       rev_valid
);
	// Unlocked and silent at power-up
	initial begin
		rx_lock = 1'b0;
		cap_load_valid = 1'b0;
		cap_load_data = 8'h5A;
		rev_valid = 1'b0;
	end
	// Lock indication, changed away from the sampling edge
	task automatic lock(input logic v);
		@(negedge clock);
		rx_lock = v;
	endtask
	// One capability word; the bus shows the inverse afterwards so stale data never looks valid
	task automatic load(input logic [7:0] d);
		@(negedge clock);
		cap_load_data = d;
		cap_load_valid = 1'b1;
		@(negedge clock);
		cap_load_valid = 1'b0;
		cap_load_data = ~d;
	endtask
	// One valid reverse-channel reception
	task automatic ping();
		@(negedge clock);
		rev_valid = 1'b1;
		@(negedge clock);
		rev_valid = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: tb/remote_capability_and_link_detect_tb.sv
// Self-checking bench for the capability bank and link-detect timer
`timescale 1ns/100ps
`default_nettype none
module remote_capability_and_link_detect_tb;
	import rcl_pkg::*;
	// Short counts keep the two longest timeouts cheap; 325 us runs at its true length
	localparam logic [15:0] T2 = 16'h003C;
	localparam logic [15:0] T3 = 16'h0050;
	localparam logic [15:0] TMO [8] = '{16'h0CA8, 16'h1964, T2, T3, 16'h00CD, 16'h019A, 16'h0334, 16'h0668};
	logic       clock, nrst, scl, sda_m, sda_out, sda_oe, rx_lock, clv, rev_valid, link_detect;
	logic [7:0] cld;
	wire  logic [4:0] caps;
	wire  logic sda_w;
	int         errors = 0;
	int         comparisons = 0;
	// Open-drain wire: pulled up unless someone pulls low
	assign sda_w = sda_m & (~sda_oe | sda_out);
	rcl_top #(
		.CYC_650_P  (T2),
		.CYC_1300_P (T3)
	) i_dut (
		.clock                     (clock),
		.nrst                      (nrst),
		.scl_in                    (scl),
		.sda_in                    (sda_w),
		.sda_out                   (sda_out),
		.sda_oe                    (sda_oe),
		.rx_lock                   (rx_lock),
		.cap_load_valid            (clv),
		.cap_load_data             (cld),
		.rev_valid                 (rev_valid),
		.send_equalizer_pattern    (caps[4]),
		.two_link_capable          (caps[3]),
		.secondary_channel         (caps[2]),
		.wide_video_with_hd_sound  (caps[1]),
		.forward_frame_pin_support (caps[0]),
		.link_detect               (link_detect)
	);
	rcl_peer i_peer (
		.clock          (clock),
		.rx_lock        (rx_lock),
		.cap_load_valid (clv),
		.cap_load_data  (cld),
		.rev_valid      (rev_valid)
	);
	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// ********
	// Helpers
	// ********
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One bus bit; SDA moves a clock after SCL falls, never with it
	task automatic bit_io(input logic b, output logic r);
		cyc(1);
		sda_m = b;
		cyc(5);
		scl = 1'b1;
		cyc(3);
		r = sda_w;
		cyc(3);
		scl = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
		bit_io(mack, ack);
	endtask
	task automatic start();
		cyc(1);
		sda_m = 1'b1;
		cyc(3);
		scl = 1'b1;
		cyc(5);
		sda_m = 1'b0;
		cyc(5);
		scl = 1'b0;
	endtask
	task automatic stop();
		cyc(1);
		sda_m = 1'b0;
		cyc(3);
		scl = 1'b1;
		cyc(5);
		sda_m = 1'b1;
		cyc(5);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic       k0, k1, k2;
		start();
		xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, r, k0);
		xfer(a, 1'b1, r, k1);
		xfer(d, 1'b1, r, k2);
		stop();
		chk({5'h00, k0, k1, k2}, 8'h00);
	endtask
	// Pointer write, repeated start, one byte read closed by a master nack
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] r, d;
		logic       k0, k1, k2, k3;
		start();
		xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, r, k0);
		xfer(a, 1'b1, r, k1);
		start();
		xfer({I2C_DEV_ADDR, 1'b1}, 1'b1, r, k2);
		xfer(8'hFF, 1'b1, d, k3);
		stop();
		chk({5'h00, k0, k1, k2}, 8'h00);
		chk(d, exp);
	endtask
	// ********
	// Scenarios
	// ********
	task automatic s_reset();
		rd(8'h20, CAP_FLAGS_RESET);
		rd(8'h21, 8'h00);
		rd(8'h26, 8'h00);
		chk({2'h0, link_detect, caps}, 8'h00);
	endtask
	// Unlocked words are dropped, locked ones land bit by bit
	task automatic s_auto();
		i_peer.load(8'h1F);
		cyc(3);
		chk({3'h0, caps}, 8'h00);
		i_peer.lock(1'b1);
		cyc(4);
		for (int i = 0; i < 5; i++) begin
			i_peer.load(8'h01 << i);
			cyc(2);
			chk({3'h0, caps}, 8'h01 << i);
		end
		i_peer.load(8'hFF);
		rd(8'h20, 8'h1F);
	endtask
	// Without hold a software value gives way; with hold it stays
	task automatic s_hold();
		wr(8'h20, 8'h03);
		cyc(2);
		chk({3'h0, caps}, 8'h03);
		i_peer.load(8'h1C);
		rd(8'h20, 8'h1C);
		wr(8'h20, 8'h91);
		i_peer.load(8'h0E);
		cyc(2);
		chk({3'h0, caps}, 8'h11);
		rd(8'h20, 8'h91);
		wr(8'h20, 8'hFF);
		rd(8'h20, 8'h9F);
		wr(8'h21, 8'hFF);
		rd(8'h21, 8'h00);
		wr(8'h20, 8'h00);
		i_peer.load(8'h0A);
		cyc(2);
		chk({3'h0, caps}, 8'h0A);
	endtask
	// Wrong device address gets no acknowledge and changes nothing
	task automatic s_refuse();
		logic [7:0] r;
		logic       k;
		start();
		xfer(8'h1A, 1'b1, r, k);
		xfer(8'h20, 1'b1, r, k);
		stop();
		chk({7'h00, k}, 8'h01);
		rd(8'h20, 8'h0A);
	endtask
	// Bursts: the pointer steps after each byte written or read
	task automatic s_burst();
		logic [7:0] r, d0, d1;
		logic       k0, k1, k2, k3;
		start();
		xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, r, k0);
		xfer(8'h1F, 1'b1, r, k1);
		xfer(8'h55, 1'b1, r, k2);
		xfer(8'h85, 1'b1, r, k3);
		stop();
		chk({4'h0, k0, k1, k2, k3}, 8'h00);
		chk({3'h0, caps}, 8'h05);
		start();
		xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, r, k0);
		xfer(8'h20, 1'b1, r, k1);
		start();
		xfer({I2C_DEV_ADDR, 1'b1}, 1'b1, r, k2);
		xfer(8'hFF, 1'b0, d0, k3);
		xfer(8'hFF, 1'b1, d1, k3);
		stop();
		chk({5'h00, k0, k1, k2}, 8'h00);
		chk(d0, 8'h85);
		chk(d1, 8'h00);
	endtask
	// Every timeout code: high just before expiry, low just after
	task automatic s_timer();
		for (int s = 0; s < 8; s++) begin
			wr(8'h26, 8'hF8 | 8'(s));
			rd(8'h26, 8'(s));
			i_peer.ping();
			cyc(int'(TMO[s]) - 1);
			chk({7'h00, link_detect}, 8'h01);
			cyc(3);
			chk({7'h00, link_detect}, 8'h00);
		end
	endtask
	task automatic s_restart();
		wr(8'h26, 8'h04);
		i_peer.ping();
		cyc(100);
		i_peer.ping();
		cyc(200);
		chk({7'h00, link_detect}, 8'h01);
		cyc(8);
		chk({7'h00, link_detect}, 8'h00);
	endtask
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		nrst = 1'b0;
		scl = 1'b1;
		sda_m = 1'b1;
		cyc(20);
		nrst = 1'b1;
		cyc(4);
		s_reset();
		s_auto();
		s_hold();
		s_refuse();
		s_burst();
		s_timer();
		s_restart();
		print_verdict();
	end
	// Watchdog, well beyond the roughly 27600 cycles the tests need
	initial begin
		cyc(60000);
		errors++;
		print_verdict();
	end
endmodule
`default_nettype wire
